// *** core/cfb_defines.svh ***
/*
  register indices, reset values and decode limits of the filter coefficient bank.
  assumes: included by the bank's package and modules; definitions only.
*/
`ifndef CFB_DEFINES_SVH
`define CFB_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define CFB_IDX_RFX_DEN5_LO 8'h2e
`define CFB_IDX_RDE_NUM0_HI 8'h2f
`define CFB_IDX_RDE_NUM0_LO 8'h30
`define CFB_IDX_RDE_NUM1_HI 8'h31
`define CFB_IDX_RDE_NUM1_LO 8'h32
`define CFB_IDX_RDE_DEN1_HI 8'h33
`define CFB_IDX_RDE_DEN1_LO 8'h34
`define CFB_IDX_SPA_ATT_HI 8'h35
`define CFB_IDX_SPA_ATT_LO 8'h36
`define CFB_IDX_RSVD_FIRST 8'h37
`define CFB_IDX_RSVD_LAST 8'h40
`define CFB_IDX_LHP_NUM0_HI 8'h41

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CFB_RST_RFX_DEN5_LO 8'hee
`define CFB_RST_RDE_NUM0_HI 8'h39
`define CFB_RST_RDE_NUM0_LO 8'h55
`define CFB_RST_RDE_NUM1_HI 8'hf3
`define CFB_RST_RDE_NUM1_LO 8'h2d
`define CFB_RST_RDE_DEN1_HI 8'h53
`define CFB_RST_RDE_DEN1_LO 8'h7e
`define CFB_RST_SPA_ATT_HI 8'h7f
`define CFB_RST_SPA_ATT_LO 8'hff
`define CFB_RST_RSVD 8'h00
`define CFB_RST_LHP_NUM0_HI 8'h39

// ----------------------------------------------------------------
// storage slots and bus layout
// ----------------------------------------------------------------
`define CFB_SLOTS 10
`define CFB_SLOT_LHP 4'h9
`define CFB_PAIRS 4
`define CFB_IDX_LSB 2
`define CFB_IDX_MSB 9
`define CFB_RDPAD 24'h00_0000

`endif

// *** core/cfb_pkg.sv ***
/*
  types shared by the coefficient bank modules.
  assumes: cfb_defines.svh is on the include path.
*/
`include "cfb_defines.svh"

package cfb_pkg;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CFB_TR_IDLE = 2'h0,
    CFB_TR_BUSY = 2'h1,
    CFB_TR_NSEQ = 2'h2,
    CFB_TR_SEQ = 2'h3
  } cfb_trans_t;

  // ----------------------------------------------------------------
  // data-phase state of the bus slave
  // ----------------------------------------------------------------
  typedef struct packed {
    logic act;
    logic wr;
    logic hit;
    logic rsvd;
    logic [3:0] slot;
  } cfb_dphase_t;

  typedef logic signed [15:0] cfb_coef_t;

endpackage : cfb_pkg

// *** core/cfb_byte_store.sv ***
/*
  small byte store for the coefficient bank: one write port, one read port
  whose data come out of a register, and every byte visible as a flat bus.
  assumes: single clock, synchronous active-high reset, clock enable.
*/
`timescale 1ns/1ps
`include "cfb_defines.svh"

module cfb_byte_store import cfb_pkg::*; #(
  parameter int N = `CFB_SLOTS,
  parameter logic [N*8-1:0] RESET_V = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [3:0] wr_slot,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic rd_valid,
  input wire logic [3:0] rd_slot,
  output logic [7:0] rd_data,
  output logic [N*8-1:0] bytes_q
);

  if (N < 1 || N > 16) begin : g_bad_n
    $error("cfb_byte_store: N must be 1 to 16");
  end

  typedef struct packed {
    logic [N-1:0][7:0] mem;
    logic [7:0] rd;
  } cfb_store_st_t;

  cfb_store_st_t st_r;
  cfb_store_st_t st_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (wr_en && int'(wr_slot) < N) begin
      st_nxt.mem[wr_slot] = wr_data;
    end
    if (rd_en) begin
      // forward a write landing in the same cycle so a read never sees stale data
      if (!rd_valid || int'(rd_slot) >= N) begin
        st_nxt.rd = 8'h00;
      end else if (wr_en && wr_slot == rd_slot) begin
        st_nxt.rd = wr_data;
      end else begin
        st_nxt.rd = st_r.mem[rd_slot];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r.mem <= RESET_V;
      st_r.rd <= 8'h00;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd;
  assign bytes_q = st_r.mem;

endmodule : cfb_byte_store

// *** core/cfb_coef_bank.sv ***
/*
  filter coefficient bank: ten byte registers on a 32-bit AHB-Lite slave,
  eight of them paired into four signed 16-bit coefficients for the filter datapaths, two left as single bytes.
  assumes: one AHB-Lite master, this slave's hreadyout is the bus hready,
  single clock, synchronous active-high reset, clock enable freezes state.
*/
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cfb_defines.svh"

module cfb_coef_bank import cfb_pkg::*; #(
  parameter int ADDR_W = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [7:0] right_effects_den5_low,
  output cfb_coef_t right_deemph_numerator_tap_zero,
  output cfb_coef_t right_deemph_numerator_tap_one,
  output cfb_coef_t right_deemph_denominator_tap_one,
  output cfb_coef_t spatial_atten,
  output logic [7:0] left_adc_highpass_num0_high
);

  if (ADDR_W < `CFB_IDX_MSB + 1 || ADDR_W > 32) begin : g_bad_addr
    $error("cfb_coef_bank: ADDR_W must be 10 to 32");
  end

  // ----------------------------------------------------------------
  // reset image, slot 0 in the low byte
  // ----------------------------------------------------------------
  localparam logic [`CFB_SLOTS*8-1:0] RESET_IMG = {
    `CFB_RST_LHP_NUM0_HI,
    `CFB_RST_SPA_ATT_LO,
    `CFB_RST_SPA_ATT_HI,
    `CFB_RST_RDE_DEN1_LO,
    `CFB_RST_RDE_DEN1_HI,
    `CFB_RST_RDE_NUM1_LO,
    `CFB_RST_RDE_NUM1_HI,
    `CFB_RST_RDE_NUM0_LO,
    `CFB_RST_RDE_NUM0_HI,
    `CFB_RST_RFX_DEN5_LO
  };

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // indices 0x2e..0x36 are contiguous slots 0..8; 0x41 is slot 9
  function automatic logic [3:0] slot_of(input logic [7:0] idx);
    logic [7:0] off;
    off = idx - `CFB_IDX_RFX_DEN5_LO;
    if (idx == `CFB_IDX_LHP_NUM0_HI) begin
      return `CFB_SLOT_LHP;
    end
    return off[3:0];
  endfunction : slot_of

  function automatic logic is_coef(input logic [7:0] idx);
    return (idx >= `CFB_IDX_RFX_DEN5_LO && idx <= `CFB_IDX_SPA_ATT_LO)
      || idx == `CFB_IDX_LHP_NUM0_HI;
  endfunction : is_coef

  function automatic logic is_rsvd(input logic [7:0] idx);
    return idx >= `CFB_IDX_RSVD_FIRST && idx <= `CFB_IDX_RSVD_LAST;
  endfunction : is_rsvd

  logic [7:0] a_idx;
  logic a_upper_zero;
  logic a_lane0;
  logic a_hit;
  logic take;

  assign a_idx = haddr[`CFB_IDX_MSB:`CFB_IDX_LSB];
  assign a_lane0 = haddr[1:0] == 2'b00;
  assign a_upper_zero = (ADDR_W > `CFB_IDX_MSB + 1)
    ? ((haddr >> (`CFB_IDX_MSB + 1)) == '0) : 1'b1;
  // only lane 0 of an aligned word holds a register; upper bytes read as zero
  assign a_hit = a_upper_zero && a_lane0 && is_coef(a_idx);
  // a transfer is taken only while the bank runs, since hready follows ce
  assign take = hsel && hready && htrans[1] && ce;

  // ----------------------------------------------------------------
  // data-phase state
  // ----------------------------------------------------------------
  cfb_dphase_t st_r;
  cfb_dphase_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (hready && ce) begin
      st_nxt.act = take;
      st_nxt.wr = take && hwrite;
      st_nxt.hit = take && a_hit;
      st_nxt.rsvd = take && a_upper_zero && is_rsvd(a_idx);
      st_nxt.slot = slot_of(a_idx);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_byte;
  logic [`CFB_SLOTS*8-1:0] bytes_w;

  // reserved and unmapped indices never reach the store, so they keep reading zero
  assign wr_en = st_r.act && st_r.wr && st_r.hit && ce;
  assign rd_en = take && !hwrite;

  cfb_byte_store #(
    .N(`CFB_SLOTS),
    .RESET_V(RESET_IMG)
  ) u_store (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .wr_en(wr_en),
    .wr_slot(st_r.slot),
    .wr_data(hwdata[7:0]),
    .rd_en(rd_en),
    .rd_valid(a_hit),
    .rd_slot(slot_of(a_idx)),
    .rd_data(rd_byte),
    .bytes_q(bytes_w)
  );

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  // zero wait states; a low ce stretches the data phase instead of losing it
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = {`CFB_RDPAD, rd_byte};

  // ----------------------------------------------------------------
  // coefficient pairing
  // ----------------------------------------------------------------
  cfb_coef_t coef_w [`CFB_PAIRS];

  for (genvar p = 0; p < `CFB_PAIRS; p++) begin : g_pair
    // high slot 2p+1 gives bits 15:8, low slot 2p+2 bits 7:0
    assign coef_w[p] = {bytes_w[(2*p+1)*8 +: 8], bytes_w[(2*p+2)*8 +: 8]};
  end

  assign right_effects_den5_low = bytes_w[7:0];
  assign right_deemph_numerator_tap_zero = coef_w[0];
  assign right_deemph_numerator_tap_one = coef_w[1];
  assign right_deemph_denominator_tap_one = coef_w[2];
  assign spatial_atten = coef_w[3];
  assign left_adc_highpass_num0_high = bytes_w[`CFB_SLOT_LHP*8 +: 8];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic wr_go;
  assign wr_go = st_r.act && st_r.wr && st_r.hit && ce;

  a_pair_low_write: assert property (
    wr_go && st_r.slot == 4'h2
    |=> right_deemph_numerator_tap_zero[7:0] == $past(hwdata[7:0])
      && right_deemph_numerator_tap_zero[15:8] == $past(right_deemph_numerator_tap_zero[15:8]))
    else $error("low byte write did not land in coefficient bits 7:0");

  a_den5_reset_write: assert property (
    ($fell(rst) |-> right_effects_den5_low == `CFB_RST_RFX_DEN5_LO)
    and (wr_go && st_r.slot == 4'h0 |=> right_effects_den5_low == $past(hwdata[7:0])))
    else $error("effects low byte reset or write wrong");

  a_num0_reset: assert property (
    $fell(rst) |-> right_deemph_numerator_tap_zero
      == {`CFB_RST_RDE_NUM0_HI, `CFB_RST_RDE_NUM0_LO})
    else $error("tap-zero numerator reset value wrong");

  a_num1_reset: assert property (
    $fell(rst) |-> right_deemph_numerator_tap_one
      == {`CFB_RST_RDE_NUM1_HI, `CFB_RST_RDE_NUM1_LO})
    else $error("tap-one numerator reset value wrong");

  a_den1_reset_write: assert property (
    ($fell(rst) |-> right_deemph_denominator_tap_one
      == {`CFB_RST_RDE_DEN1_HI, `CFB_RST_RDE_DEN1_LO})
    and (wr_go && st_r.slot == 4'h6
      |=> right_deemph_denominator_tap_one[7:0] == $past(hwdata[7:0])))
    else $error("tap-one denominator reset or write wrong");

  a_atten_reset: assert property (
    $fell(rst) |-> spatial_atten == {`CFB_RST_SPA_ATT_HI, `CFB_RST_SPA_ATT_LO}
      && spatial_atten > 0)
    else $error("attenuation reset is not the largest positive value");

  a_rsvd_reads_zero: assert property (
    st_r.act && st_r.rsvd && !st_r.wr |-> hrdata == 32'h0000_0000)
    else $error("reserved index read returned nonzero data");

  a_rsvd_no_write: assert property (
    st_r.act && st_r.wr && !st_r.hit && ce |=> $stable(bytes_w))
    else $error("write to reserved or unmapped index changed a register");

  a_hp_reset_write: assert property (
    ($fell(rst) |-> left_adc_highpass_num0_high == `CFB_RST_LHP_NUM0_HI)
    and (wr_go && st_r.slot == `CFB_SLOT_LHP
      |=> left_adc_highpass_num0_high == $past(hwdata[7:0])))
    else $error("high-pass high byte reset or write wrong");

  a_sign_from_high: assert property (
    wr_go && st_r.slot == 4'h7
    |=> spatial_atten[15] == $past(hwdata[7])
      && spatial_atten[15:8] == $past(hwdata[7:0]))
    else $error("high byte did not set coefficient bits 15:8 and sign");

  a_read_returns: assert property (
    take && !hwrite && a_hit && slot_of(a_idx) == 4'h3 && !wr_go
    |=> hrdata[7:0] == right_deemph_numerator_tap_one[15:8])
    else $error("read of a high byte disagrees with coefficient bits");

  // each byte write lands in its own half of its coefficient, one edge after the data phase
  a_num0_high_write: assert property (
    wr_go && st_r.slot == 4'h1
    |=> right_deemph_numerator_tap_zero[15:8] == $past(hwdata[7:0])
      && right_deemph_numerator_tap_zero[7:0] == $past(right_deemph_numerator_tap_zero[7:0]))
    else $error("tap-zero numerator high byte write wrong");

  a_num1_write: assert property (
    (wr_go && st_r.slot == 4'h3
      |=> right_deemph_numerator_tap_one[15:8] == $past(hwdata[7:0]))
    and (wr_go && st_r.slot == 4'h4
      |=> right_deemph_numerator_tap_one[7:0] == $past(hwdata[7:0])))
    else $error("tap-one numerator byte write wrong");

  a_den1_high_write: assert property (
    wr_go && st_r.slot == 4'h5
    |=> right_deemph_denominator_tap_one[15:8] == $past(hwdata[7:0]))
    else $error("tap-one denominator high byte write wrong");

  a_atten_low_write: assert property (
    wr_go && st_r.slot == 4'h8
    |=> spatial_atten[7:0] == $past(hwdata[7:0]))
    else $error("attenuation low byte write wrong");

  // slot 9 sits right after the attenuation pair, so an aliased decode would hit it
  a_hp_write_alone: assert property (
    wr_go && st_r.slot == `CFB_SLOT_LHP
    |=> $stable(spatial_atten) && $stable(right_effects_den5_low))
    else $error("high-pass byte write disturbed another register");

  a_read_low_byte: assert property (
    take && !hwrite && a_hit && slot_of(a_idx) == 4'h4 && !wr_go
    |=> hrdata[7:0] == right_deemph_numerator_tap_one[7:0])
    else $error("read of a low byte disagrees with coefficient bits");

  // a miss must clear the read byte, or it would show whatever the last hit left there
  a_miss_reads_zero: assert property (
    take && !hwrite && !a_hit |=> hrdata == 32'h0000_0000)
    else $error("read of a reserved or unmapped index returned nonzero data");

  // a low ce must freeze every byte and the read data, or a stalled read would drift
  a_frozen_state: assert property (
    !ce
    |=> $stable(bytes_w) && $stable(hrdata))
    else $error("state changed while the clock enable was low");

  a_bytes_hold: assert property (
    !wr_go |=> $stable(bytes_w))
    else $error("a register changed without a bus write");

  a_read_held: assert property (
    !rd_en |=> $stable(hrdata))
    else $error("read data changed without a new read");

endmodule : cfb_coef_bank

// *** tb/codec_filter_coefficient_bank_test.sv ***
/*
  self-checking bench for the filter coefficient bank: reset values, read/write
  of every byte, signed pairing, reserved and unmapped places, clock-enable stall.
  assumes: cfb_pkg and cfb_defines.svh compiled first; single clock, no partner.
*/
`timescale 1ns/1ps
`include "cfb_defines.svh"

module codec_filter_coefficient_bank_test import cfb_pkg::*; ;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk, rst, ce, hsel, hwrite, hreadyout, hresp;
  wire logic hready;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] den5_lo, lhp_hi;
  cfb_coef_t num0, num1, den1, spatial;
  logic [7:0] idx_tab [10];
  logic [7:0] rst_tab [10];
  logic [7:0] inv_tab [10];
  int num_errors, n_tests, cycles;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  cfb_coef_bank #(.ADDR_W(32)) dut (
    .core_clk(core_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .right_effects_den5_low(den5_lo), .right_deemph_numerator_tap_zero(num0),
    .right_deemph_numerator_tap_one(num1), .right_deemph_denominator_tap_one(den1),
    .spatial_atten(spatial), .left_adc_highpass_num0_high(lhp_hi)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  task automatic tally_and_finish;
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // a hang in the bus handshake ends here rather than running forever
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      tally_and_finish;
    end
  end

  // ----------------------------------------------------------------
  // bus master: one single transfer, waits on hready, no fixed latency
  // ----------------------------------------------------------------
  task automatic xfer(input logic [31:0] addr, input logic wr, input logic [7:0] wdat,
                      input logic sel, output logic [31:0] rdat);
    hsel <= sel;
    haddr <= addr;
    htrans <= CFB_TR_NSEQ;
    hwrite <= wr;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= CFB_TR_IDLE;
    // upper lanes carry junk so that only the low byte may be stored
    hwdata <= {24'hab_cdef, wdat};
    do @(posedge core_clk); while (hready !== 1'b1);
    rdat = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] junk;
    xfer({22'h0, idx, 2'h0}, 1'b1, d, 1'b1, junk);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] got;
    xfer({22'h0, idx, 2'h0}, 1'b0, 8'h00, 1'b1, got);
    chk(got, {24'h00_0000, exp});
  endtask : rd

  task automatic check_outs(input logic [7:0] v [10]);
    @(negedge core_clk);
    chk({24'h0, den5_lo}, {24'h0, v[0]});
    chk({16'h0, num0}, {16'h0, v[1], v[2]});
    chk({16'h0, num1}, {16'h0, v[3], v[4]});
    chk({16'h0, den1}, {16'h0, v[5], v[6]});
    chk({16'h0, spatial}, {16'h0, v[7], v[8]});
    chk({24'h0, lhp_hi}, {24'h0, v[9]});
  endtask : check_outs

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals;
    for (int i = 0; i < 10; i++) begin
      rd(idx_tab[i], rst_tab[i]);
    end
    check_outs(rst_tab);
  endtask : t_reset_vals

  task automatic t_write_all;
    // every bit flipped from reset, so a stuck or unwritten bit shows
    for (int i = 0; i < 10; i++) begin
      wr(idx_tab[i], inv_tab[i]);
      rd(idx_tab[i], inv_tab[i]);
    end
    check_outs(inv_tab);
    chk({31'h0, spatial < 16'sh0}, 32'h0000_0001);
  endtask : t_write_all

  task automatic t_reserved;
    for (logic [7:0] k = 8'h37; k <= 8'h40; k++) begin
      rd(k, 8'h00);
    end
  endtask : t_reserved

  task automatic t_unmapped;
    logic [31:0] got;
    wr(8'h10, 8'ha5);
    rd(8'h10, 8'h00);
    // a stray lane, a set upper address bit or a low select must leave every register alone
    xfer({22'h0, 8'h35, 2'h1}, 1'b1, 8'h12, 1'b1, got);
    xfer({22'h1, 8'h36, 2'h0}, 1'b1, 8'h34, 1'b1, got);
    xfer({22'h0, 8'h2e, 2'h0}, 1'b1, 8'h56, 1'b0, got);
    rd(8'h35, 8'h80);
    xfer({22'h0, 8'h35, 2'h2}, 1'b0, 8'h00, 1'b1, got);
    chk(got, 32'h0000_0000);
    check_outs(inv_tab);
  endtask : t_unmapped

  task automatic t_stall;
    @(posedge core_clk);
    ce <= 1'b0;
    fork
      rd(8'h35, 8'h80);
      begin
        repeat (3) @(negedge core_clk);
        chk({31'h0, hreadyout}, 32'h0000_0000);
        @(posedge core_clk);
        ce <= 1'b1;
      end
    join
  endtask : t_stall

  task automatic t_mid_reset;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_vals();
  endtask : t_mid_reset

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = CFB_TR_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    num_errors = 0;
    n_tests = 0;
    cycles = 0;
    idx_tab = '{8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h41};
    rst_tab = '{8'hee, 8'h39, 8'h55, 8'hf3, 8'h2d, 8'h53, 8'h7e, 8'h7f, 8'hff, 8'h39};
    for (int i = 0; i < 10; i++) begin
      inv_tab[i] = ~rst_tab[i];
    end
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_vals();
    t_reserved();
    t_write_all();
    t_unmapped();
    t_stall();
    t_mid_reset();
    tally_and_finish();
  end
endmodule : codec_filter_coefficient_bank_test
